// [dv/shs_cpu_model.sv]
/*
 CPU core stand-in: turns one-cycle requests into halt/stop pulses, drives
 a live bus while running. Assumes the bench pulses req_halt/req_stop.
*/
`timescale 1ns/1ps
module shs_cpu_model (
	input  wire logic sys_clk,
	input  wire logic arst_n,
	input  wire logic req_halt,
	input  wire logic req_stop,
	input  wire logic cpu_run,
	output logic      halt_exec,
	output logic      stop_exec,
	output logic      cpu_addr_strobe,
	output logic      cpu_rd_n,
	output logic      cpu_wr_n,
	output logic      cpu_ad_oe,
	output logic      cpu_wait_oe
);
	// ----------------------------------------
	// Core behaviour
	// ----------------------------------------
	// crystal-driven main clock
	// A halted core freezes its bus outputs, so parking must override them
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			halt_exec   <= 1'b0;
			stop_exec   <= 1'b0;
			cpu_addr_strobe <= 1'b1;
			cpu_rd_n    <= 1'b0;
			cpu_wr_n    <= 1'b0;
			cpu_ad_oe   <= 1'b1;
			cpu_wait_oe <= 1'b1;
		end else begin
			halt_exec <= req_halt & cpu_run;
			stop_exec <= req_stop & cpu_run;
			if (cpu_run) begin
				cpu_addr_strobe <= ~cpu_addr_strobe;
				cpu_rd_n        <= cpu_addr_strobe;
			end
		end
	end
endmodule

// [dv/tb_standby_halt_stop_control.sv]
/*
 Bench for the standby sequencer: halt wake table, deep sleep entry,
 gating, parking and wake paths. Assumes shs_cpu_model as the core.
*/
`timescale 1ns/1ps
module tb_standby_halt_stop_control
	import shs_pkg::*;
;
	typedef struct packed {logic ir, msk, prio, en, svc, nmi, tp, tm; logic [1:0] act;} shs_row_t;
	localparam int SHIFT = 12;
	logic       sys_clk, arst_n, req_halt, req_stop, cpu_on_main_clk, subsys_present, int_req;
	logic       interrupt_mask_flag, priority_select_flag, interrupt_enable_flag, in_service_priority_flag;
	logic       nmi_req, test_pin, test_mask, reset_pin_n, reg_wr, reg_rd, halt_exec, stop_exec;
	logic       cpu_addr_strobe, cpu_rd_n, cpu_wr_n, cpu_ad_oe, cpu_wait_oe, cpu_run, cpu_reset, resume;
	logic       main_osc_en, sub_osc_en, crystal_out_pin_pu, latch_hold, address_strobe, rd_n, wr_n;
	logic       ad_oe, wait_oe, tmr16_run, tmr8_run, watch_run, rto_run, csi_run, uart_run, wdt_run;
	logic       dac_run, external_interrupt_zero_en, ext_int_1_6_en;
	logic [1:0] reg_addr, resume_action, act;
	logic [7:0] reg_wdata, reg_rdata, d;
	int         err_count, compares, n, len;
	// Halt wake table: {ir,msk,prio,en,svc,nmi,tp,tm,action}, action 0 means sleep holds
	shs_row_t   rows [9] = '{10'h201, 10'h242, 10'h2a1, 10'h2c1, 10'h2e2, 10'h340, 10'h012, 10'h009, 10'h00c};

	shs_standby_ctrl #(.SETTLE_SHIFT(SHIFT)) shs_standby_ctrl_inst (
		.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec), .stop_exec(stop_exec),
		.cpu_on_main_clk(cpu_on_main_clk), .subsys_present(subsys_present), .int_req(int_req),
		.interrupt_mask_flag(interrupt_mask_flag), .priority_select_flag(priority_select_flag),
		.interrupt_enable_flag(interrupt_enable_flag), .in_service_priority_flag(in_service_priority_flag),
		.nmi_req(nmi_req), .test_pin(test_pin), .test_mask(test_mask), .reset_pin_n(reset_pin_n),
		.cpu_addr_strobe(cpu_addr_strobe), .cpu_rd_n(cpu_rd_n), .cpu_wr_n(cpu_wr_n), .cpu_ad_oe(cpu_ad_oe),
		.cpu_wait_oe(cpu_wait_oe), .cpu_run(cpu_run), .cpu_reset(cpu_reset), .resume(resume),
		.resume_action(resume_action), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
		.crystal_out_pin_pu(crystal_out_pin_pu), .latch_hold(latch_hold), .address_strobe(address_strobe),
		.rd_n(rd_n), .wr_n(wr_n), .ad_oe(ad_oe), .wait_oe(wait_oe), .tmr16_run(tmr16_run),
		.tmr8_run(tmr8_run), .watch_run(watch_run), .rto_run(rto_run), .csi_run(csi_run),
		.uart_run(uart_run), .wdt_run(wdt_run), .dac_run(dac_run),
		.external_interrupt_zero_en(external_interrupt_zero_en), .ext_int_1_6_en(ext_int_1_6_en)
	);

	shs_cpu_model shs_cpu_model_inst (
		.sys_clk(sys_clk), .arst_n(arst_n), .req_halt(req_halt), .req_stop(req_stop), .cpu_run(cpu_run),
		.halt_exec(halt_exec), .stop_exec(stop_exec), .cpu_addr_strobe(cpu_addr_strobe), .cpu_rd_n(cpu_rd_n),
		.cpu_wr_n(cpu_wr_n), .cpu_ad_oe(cpu_ad_oe), .cpu_wait_oe(cpu_wait_oe)
	);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("counts: compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic chk_state(input logic [4:0] e);
		logic [7:0] v;
		rd(REG_STATUS, v);
		cmp("state", {3'h0, e}, {3'h0, v[4:0]});
	endtask

	task automatic sleep_cmd(input logic deep);
		@(posedge sys_clk);
		req_halt <= ~deep;
		req_stop <= deep;
		@(posedge sys_clk);
		req_halt <= 1'b0;
		req_stop <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic apply(input shs_row_t r);
		@(posedge sys_clk);
		int_req                  <= r.ir;
		interrupt_mask_flag      <= r.msk;
		priority_select_flag     <= r.prio;
		interrupt_enable_flag    <= r.en;
		in_service_priority_flag <= r.svc;
		nmi_req                  <= r.nmi;
		test_pin                 <= r.tp;
		test_mask                <= r.tm;
	endtask

	// Bounded wait for the resume pulse; n counts edges from the call
	task automatic wait_res(output logic [1:0] a, output int cnt);
		for (cnt = 0; cnt < 100; cnt++) begin
			@(posedge sys_clk);
			#1;
			if (resume === 1'b1) break;
		end
		a = resume_action;
		if (cnt == 100) begin
			$display("wrong value resume expected 1 seen 0");
			err_count++;
			tally_and_finish();
		end
	endtask

	task automatic chk_deep(input logic [7:0] g);
		#1;
		cmp("gates", g, {tmr16_run, tmr8_run, watch_run, rto_run, csi_run, uart_run, wdt_run, dac_run});
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{arst_n, req_halt, req_stop, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{int_req, interrupt_mask_flag, priority_select_flag, interrupt_enable_flag} = '0;
		{in_service_priority_flag, nmi_req, test_pin, test_mask} = '0;
		{reset_pin_n, cpu_on_main_clk, subsys_present} = 3'h7;
		err_count = 0;
		compares  = 0;
		len = (1 << SETTLE_EXP4) >> SHIFT;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(REG_SETTLE, d);
		cmp("settle_sel", 8'h04, d);
		rd(REG_PERCFG, d);
		cmp("percfg", 8'h00, d);
		wr(REG_STATUS, 8'hff);
		chk_state(5'h01);
		rd(2'h3, d);
		cmp("unmapped", 8'h00, d);
		cmp("run_bus", 8'h16, {3'h0, cpu_run, latch_hold, ad_oe, wait_oe, wr_n});
		$display("test reset_values done");
		foreach (rows[i]) begin
			sleep_cmd(1'b0);
			chk_state(5'h02);
			apply(rows[i]);
			if (rows[i].act == 2'h0) begin
				repeat (10) @(posedge sys_clk);
				chk_state(5'h02);
				@(posedge sys_clk);
				nmi_req <= 1'b1;
			end
			wait_res(act, n);
			cmp("halt_action", (rows[i].act == 2'h0) ? 8'h02 : {6'h0, rows[i].act}, {6'h0, act});
			apply(10'h000);
			$display("test halt_row %0d done", i);
		end
		cpu_on_main_clk <= 1'b0;
		sleep_cmd(1'b1);
		chk_state(5'h01);
		@(posedge sys_clk);
		cpu_on_main_clk <= 1'b1;
		sleep_cmd(1'b1);
		chk_state(5'h04);
		cmp("parking", 8'h76, {main_osc_en, sub_osc_en, crystal_out_pin_pu, latch_hold, address_strobe,
			rd_n, wr_n, ad_oe});
		cmp("ext_int", 8'h02, {5'h0, external_interrupt_zero_en, ext_int_1_6_en, wait_oe});
		chk_deep(8'h01);
		wr(REG_PERCFG, 8'h3f);
		chk_deep(8'hf9);
		@(posedge sys_clk);
		subsys_present <= 1'b0;
		chk_deep(8'h59);
		@(posedge sys_clk);
		subsys_present <= 1'b1;
		nmi_req        <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk_state(5'h04);
		apply(10'h240);
		wait_res(act, n);
		cmp("int_wake", 8'h02, {6'h0, act});
		cmp("settle_len", 8'h01, {7'h0, (n >= len && n <= len + 4)});
		apply(10'h201);
		sleep_cmd(1'b1);
		chk_state(5'h08);
		wait_res(act, n);
		cmp("pending_wake", 8'h01, {6'h0, act});
		apply(10'h000);
		$display("test stop_int done");
		wr(REG_SETTLE, 8'h00);
		sleep_cmd(1'b1);
		apply(10'h00c);
		repeat (10) @(posedge sys_clk);
		chk_state(5'h04);
		apply(10'h008);
		wait_res(act, n);
		cmp("test_wake", 8'h01, {6'h0, act});
		apply(10'h000);
		for (int k = 0; k < 2; k++) begin
			sleep_cmd(k == 0);
			reset_pin_n <= 1'b0;
			repeat (6) @(posedge sys_clk);
			#1 cmp("cpu_reset", 8'h01, {7'h0, cpu_reset});
			@(posedge sys_clk);
			reset_pin_n <= 1'b1;
			wait_res(act, n);
			cmp("reset_wake", 8'h03, {6'h0, act});
		end
		$display("test stop_test_reset done");
		sleep_cmd(1'b1);
		#1 cmp("stop_no_reset", 8'h00, {7'h0, cpu_reset});
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(REG_SETTLE, d);
		cmp("settle_sel", 8'h04, d);
		chk_state(5'h01);
		$display("test second_reset done");
		tally_and_finish();
	end
endmodule

// [rtl/shs_pkg.sv]
/*
 Constants for the standby (light and deep sleep) sequencer.
 Assumes one 25 MHz system clock that also stands for the main oscillator.
*/
package shs_pkg;
	// ----------------------------------------
	// Clock and settle times
	// ----------------------------------------
	localparam int unsigned SYS_CLK_HZ    = 25_000_000;
	localparam int          CNT_W         = 18;
	localparam logic [2:0]  SETTLE_SEL_RST = 3'h4;
	// Settle length is 2^exp main clock cycles, chosen by the select field
	localparam int unsigned SETTLE_EXP0   = 12;
	localparam int unsigned SETTLE_EXP1   = 14;
	localparam int unsigned SETTLE_EXP2   = 15;
	localparam int unsigned SETTLE_EXP3   = 16;
	localparam int unsigned SETTLE_EXP4   = 17;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [1:0] REG_SETTLE = 2'h0;
	localparam logic [1:0] REG_PERCFG = 2'h1;
	localparam logic [1:0] REG_STATUS = 2'h2;
	localparam logic [7:0] PERCFG_RST = 8'h00;
	// Peripheral configuration bits
	localparam int CFG_T16_WATCH = 0;
	localparam int CFG_WATCH_SUB = 1;
	localparam int CFG_T8_EXT    = 2;
	localparam int CFG_RTO_TRIG  = 3;
	localparam int CFG_RTO_T8    = 4;
	localparam int CFG_CSI_EXT   = 5;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_RUN    = 5'h01,
		ST_HALT   = 5'h02,
		ST_STOP   = 5'h04,
		ST_SETTLE = 5'h08,
		ST_RESET  = 5'h10
	} shs_state_t;

	typedef enum logic [1:0] {
		ACT_NONE   = 2'h0,
		ACT_NEXT   = 2'h1,
		ACT_VECTOR = 2'h2,
		ACT_RESET  = 2'h3
	} shs_action_t;

	typedef enum logic [1:0] {
		WAKE_INT   = 2'h0,
		WAKE_TEST  = 2'h1,
		WAKE_RESET = 2'h2
	} shs_wake_t;
endpackage

// [rtl/shs_settle_timer.sv]
/*
 Oscillator settle counter: one start pulse, one done pulse after len cycles.
 Assumes len is at least one and stands while busy.
*/
`timescale 1ns/1ps
module shs_settle_timer
	import shs_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	input  wire logic             start,
	input  wire logic [CNT_W-1:0] len,
	output logic                  busy,
	output logic                  done
);
	typedef struct packed {
		logic             busy;
		logic             done;
		logic [CNT_W-1:0] cnt;
	} shs_tmr_t;

	shs_tmr_t s_q;
	shs_tmr_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (start) begin
			s_d.busy = 1'b1;
			s_d.cnt  = len - CNT_W'(1);
		end else if (s_q.busy) begin
			if (s_q.cnt == '0) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = s_q.busy;
	assign done = s_q.done;
endmodule

// [rtl/shs_standby_ctrl.sv]
/*
 Standby sequencer: light sleep, deep sleep, settle wait and wake decisions,
 plus peripheral run gating in deep sleep and bus pin parking while asleep.
 Assumes the CPU gives one-cycle halt/stop pulses and the interrupt
 controller sits on sys_clk; reset and test pins are asynchronous.
*/
// Operation
// - Reset pin ends light sleep and restarts from the reset vector
// - Maskable wake: mask holds sleep; enable and priority pick service or next
// - Non-maskable request ends light sleep and always vectors
// - Unmasked test input ends light sleep to next instruction; masked holds
// - Deep sleep entered only by the stop instruction
// - Deep sleep only while running from the main clock
// - Crystal output pulled up in deep sleep; no external main clock then
// - Pending unmasked request at stop: no deep sleep, straight to settle wait
// - Deep sleep stops only the main oscillator; subsystem keeps running
// - Deep sleep holds latches and address, floats data and wait, parks strobes
// - 16-bit timer runs only on watch output with watch on subsystem clock
// - 8-bit timers run only on external count inputs
// - Watch timer runs only on an existing subsystem clock
// - Real-time output runs on external trigger or external-clocked 8-bit timers
// - Clocked serial runs only on external clock; automatic mode and UART stop
// - Deep sleep ends only on interrupt, test input or reset, after settling
// - Interrupt wake from deep sleep vectors if accepted, else next
// - Test wake from deep sleep resumes after the stop instruction
// - Reset wake from deep sleep does reset processing after settling
`timescale 1ns/1ps
module shs_standby_ctrl
	import shs_pkg::*;
#(
	parameter int unsigned SETTLE_SHIFT = 0
)(
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       halt_exec,
	input  wire logic       stop_exec,
	input  wire logic       cpu_on_main_clk,
	input  wire logic       subsys_present,
	input  wire logic       int_req,
	input  wire logic       interrupt_mask_flag,
	input  wire logic       priority_select_flag,
	input  wire logic       interrupt_enable_flag,
	input  wire logic       in_service_priority_flag,
	input  wire logic       nmi_req,
	input  wire logic       test_pin,
	input  wire logic       test_mask,
	input  wire logic       reset_pin_n,
	input  wire logic       cpu_addr_strobe,
	input  wire logic       cpu_rd_n,
	input  wire logic       cpu_wr_n,
	input  wire logic       cpu_ad_oe,
	input  wire logic       cpu_wait_oe,
	output logic            cpu_run,
	output logic            cpu_reset,
	output logic            resume,
	output logic      [1:0] resume_action,
	output logic            main_osc_en,
	output logic            sub_osc_en,
	output logic            crystal_out_pin_pu,
	output logic            latch_hold,
	output logic            address_strobe,
	output logic            rd_n,
	output logic            wr_n,
	output logic            ad_oe,
	output logic            wait_oe,
	output logic            tmr16_run,
	output logic            tmr8_run,
	output logic            watch_run,
	output logic            rto_run,
	output logic            csi_run,
	output logic            uart_run,
	output logic            wdt_run,
	output logic            dac_run,
	output logic            external_interrupt_zero_en,
	output logic            ext_int_1_6_en
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Service decision used on light sleep wake and after settling
	function automatic logic take_service(input logic masked, input logic prio,
		input logic enable, input logic in_svc);
		take_service = !masked && enable && (!prio || in_svc);
	endfunction

	function automatic logic [CNT_W-1:0] settle_len(input logic [2:0] sel);
		logic [CNT_W:0] full;
		logic [CNT_W:0] cut;
		full = '0;
		case (sel)
			3'h0:    full[SETTLE_EXP0] = 1'b1;
			3'h1:    full[SETTLE_EXP1] = 1'b1;
			3'h2:    full[SETTLE_EXP2] = 1'b1;
			3'h3:    full[SETTLE_EXP3] = 1'b1;
			default: full[SETTLE_EXP4] = 1'b1;
		endcase
		cut = full >> SETTLE_SHIFT;
		// Never shorter than one cycle
		settle_len = (cut == '0) ? CNT_W'(1) : cut[CNT_W-1:0];
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		shs_state_t  st;
		shs_wake_t   cause;
		shs_action_t act;
		logic        resume;
		logic [2:0]  settle_sel;
		logic [7:0]  cfg;
		logic [7:0]  rdata;
		logic [1:0]  sync1;
		logic [1:0]  sync2;
	} shs_ctl_t;

	shs_ctl_t s_q;
	shs_ctl_t s_d;
	logic     tmr_start;
	logic     tmr_busy;
	logic     tmr_done;
	logic     rst_req;
	logic     test_wake;
	logic     int_wake;
	logic     deep;

	// Pins pass two flops; only the second is read
	assign rst_req   = !s_q.sync2[0];
	assign test_wake = s_q.sync2[1] && !test_mask;
	assign int_wake  = int_req && !interrupt_mask_flag;
	assign deep      = (s_q.st == ST_STOP) || (s_q.st == ST_SETTLE);

	always_comb begin
		s_d = s_q;
		s_d.sync1 = {test_pin, reset_pin_n};
		s_d.sync2 = s_q.sync1;
		s_d.resume = 1'b0;
		s_d.rdata = 8'h00;
		tmr_start = 1'b0;
		// Register port
		if (reg_wr) begin
			case (reg_addr)
				REG_SETTLE: s_d.settle_sel = reg_wdata[2:0];
				REG_PERCFG: s_d.cfg = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				REG_SETTLE: s_d.rdata = {5'h00, s_q.settle_sel};
				REG_PERCFG: s_d.rdata = s_q.cfg;
				REG_STATUS: s_d.rdata = {1'b0, s_q.act, s_q.st};
				default:    s_d.rdata = 8'h00;
			endcase
		end
		// Sleep sequencing
		case (s_q.st)
			ST_RUN: begin
				if (rst_req) begin
					s_d.st = ST_RESET;
				end else if (halt_exec) begin
					s_d.st = ST_HALT;
				end else if (stop_exec && cpu_on_main_clk) begin
					// Pending request turns stop into settle
					if (int_wake) begin
						s_d.st = ST_SETTLE;
						s_d.cause = WAKE_INT;
						tmr_start = 1'b1;
					end else begin
						s_d.st = ST_STOP;
					end
				end
			end
			ST_HALT: begin
				if (rst_req) begin
					s_d.st = ST_RESET;
				end else if (nmi_req) begin
					s_d.st = ST_RUN;
					s_d.act = ACT_VECTOR;
					s_d.resume = 1'b1;
				end else if (int_wake) begin
					s_d.st = ST_RUN;
					s_d.act = take_service(interrupt_mask_flag, priority_select_flag,
						interrupt_enable_flag, in_service_priority_flag) ? ACT_VECTOR : ACT_NEXT;
					s_d.resume = 1'b1;
				end else if (test_wake) begin
					s_d.st = ST_RUN;
					s_d.act = ACT_NEXT;
					s_d.resume = 1'b1;
				end
			end
			ST_STOP: begin
				// Only three wake sources, all settle first
				if (rst_req || int_wake || test_wake) begin
					s_d.st = ST_SETTLE;
					s_d.cause = rst_req ? WAKE_RESET : (int_wake ? WAKE_INT : WAKE_TEST);
					tmr_start = 1'b1;
				end
			end
			ST_SETTLE: begin
				if (rst_req) begin
					s_d.cause = WAKE_RESET;
				end
				if (tmr_done) begin
					s_d.resume = 1'b1;
					case (s_q.cause)
						WAKE_RESET: begin
							s_d.act = ACT_RESET;
							s_d.st = rst_req ? ST_RESET : ST_RUN;
							s_d.resume = !rst_req;
						end
						WAKE_TEST: begin
							s_d.act = ACT_NEXT;
							s_d.st = ST_RUN;
						end
						default: begin
							s_d.act = take_service(interrupt_mask_flag, priority_select_flag,
								interrupt_enable_flag, in_service_priority_flag) ? ACT_VECTOR : ACT_NEXT;
							s_d.st = ST_RUN;
						end
					endcase
				end
			end
			ST_RESET: begin
				if (!rst_req) begin
					s_d.st = ST_RUN;
					s_d.act = ACT_RESET;
					s_d.resume = 1'b1;
				end
			end
			default: s_d.st = ST_RUN;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q.st         <= ST_RUN;
			s_q.cause      <= WAKE_INT;
			s_q.act        <= ACT_NONE;
			s_q.resume     <= 1'b0;
			s_q.settle_sel <= SETTLE_SEL_RST;
			s_q.cfg        <= PERCFG_RST;
			s_q.rdata      <= 8'h00;
			s_q.sync1      <= 2'h1;
			s_q.sync2      <= 2'h1;
		end else begin
			s_q <= s_d;
		end
	end

	shs_settle_timer u_settle (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.start   (tmr_start),
		.len     (settle_len(s_q.settle_sel)),
		.busy    (tmr_busy),
		.done    (tmr_done)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata     = s_q.rdata;
	assign resume        = s_q.resume;
	assign resume_action = s_q.act;
	assign cpu_run       = (s_q.st == ST_RUN);
	assign cpu_reset     = (s_q.st == ST_RESET) || ((s_q.st == ST_SETTLE) && s_q.cause == WAKE_RESET);
	assign main_osc_en = (s_q.st != ST_STOP);
	assign sub_osc_en  = 1'b1;
	assign crystal_out_pin_pu = (s_q.st == ST_STOP);
	assign latch_hold     = !cpu_run;
	assign address_strobe = cpu_run && cpu_addr_strobe;
	assign rd_n           = !cpu_run || cpu_rd_n;
	assign wr_n           = !cpu_run || cpu_wr_n;
	assign ad_oe          = cpu_run && cpu_ad_oe;
	assign wait_oe        = cpu_run && cpu_wait_oe;
	assign tmr16_run = !deep || (s_q.cfg[CFG_T16_WATCH] && s_q.cfg[CFG_WATCH_SUB] && subsys_present);
	assign tmr8_run = !deep || s_q.cfg[CFG_T8_EXT];
	assign watch_run = !deep || (s_q.cfg[CFG_WATCH_SUB] && subsys_present);
	assign rto_run = !deep || s_q.cfg[CFG_RTO_TRIG] || (s_q.cfg[CFG_RTO_T8] && s_q.cfg[CFG_T8_EXT]);
	assign csi_run  = !deep || s_q.cfg[CFG_CSI_EXT];
	assign uart_run = !deep;
	assign wdt_run                    = !deep;
	assign dac_run                    = 1'b1;
	assign external_interrupt_zero_en = !deep;
	assign ext_int_1_6_en             = 1'b1;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	chk_stop_entry_main: assert property (
		$rose(s_q.st == ST_STOP) |-> $past(stop_exec) && $past(cpu_on_main_clk))
		else $error("Deep sleep entered without stop on main clock");
	chk_stop_by_instr: assert property (
		(s_q.st == ST_STOP) && !$past(s_q.st == ST_STOP) |-> $past(s_q.st == ST_RUN))
		else $error("Deep sleep entered from wrong state");
	chk_pending_settle: assert property (
		(s_q.st == ST_RUN) && !rst_req && !halt_exec && stop_exec && cpu_on_main_clk && int_wake
		|=> s_q.st == ST_SETTLE)
		else $error("Pending request did not divert stop");
	chk_nmi_vector: assert property (
		(s_q.st == ST_HALT) && !rst_req && nmi_req |=> resume && resume_action == ACT_VECTOR)
		else $error("Non-maskable wake did not vector");
	chk_mask_holds: assert property (
		(s_q.st == ST_HALT) && !rst_req && !nmi_req && interrupt_mask_flag && !test_wake
		|=> s_q.st == ST_HALT)
		else $error("Masked request left light sleep");
	chk_halt_test_next: assert property (
		(s_q.st == ST_HALT) && !rst_req && !nmi_req && !int_wake && test_wake
		|=> resume && resume_action == ACT_NEXT)
		else $error("Test wake did not resume at next");
	chk_settle_before_run: assert property (
		(s_q.st == ST_RUN) && $past(s_q.st == ST_SETTLE) |-> $past(tmr_done))
		else $error("Left settle before timer expired");
	chk_stop_pins: assert property (
		(s_q.st == ST_STOP) |-> !ad_oe && !wait_oe && !address_strobe && rd_n && wr_n)
		else $error("Bus not parked in deep sleep");
	chk_stop_osc: assert property (
		(s_q.st == ST_STOP) |-> crystal_out_pin_pu && !main_osc_en && sub_osc_en && !wdt_run)
		else $error("Oscillator control wrong in deep sleep");
	chk_reset_restart: assert property (
		(s_q.st == ST_HALT) && rst_req |=> s_q.st == ST_RESET ##0 cpu_reset)
		else $error("Reset did not end light sleep");
	chk_settle_busy: assert property (
		(s_q.st == ST_SETTLE) |-> tmr_busy || tmr_done)
		else $error("Settle state without running timer");

	cov_halt_wake: cover property ((s_q.st == ST_HALT) ##1 resume);
	cov_stop_wake: cover property ((s_q.st == ST_STOP) ##1 (s_q.st == ST_SETTLE) ##[1:300] resume);
	cov_stop_reset: cover property ((s_q.st == ST_SETTLE) && s_q.cause == WAKE_RESET);
endmodule
